/* rtl/flash_sector_program_guard.sv */
`timescale 1ns/1ps
module flash_sector_program_guard
    import flash_guard_pkg::*;
#(
    parameter int   FLASH_KB    = 32,
    parameter bit   IS_FLASH    = 1'b1,
    parameter bit   ROM_PROTECT = 1'b0
)(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       icc_serial_clock,
    input  wire logic       icc_serial_data_in,
    output logic            icc_serial_data_out,
    output logic            icc_serial_data_oe_n,
    input  wire logic       tool_attached,
    input  wire logic       socket_mode,
    input  wire logic       protect_option_pin,
    input  wire cpu_bus_t   cpu,
    input  wire logic       flash_done,
    output flash_req_t      flash_req,
    output logic            flash_req_valid,
    output logic [7:0]      flash_ctrl_status_rdata,
    output logic            read_block,
    output logic            icc_pins_owned,
    output logic            icc_session,
    output logic            readout_protected
);
    localparam int NUM_SECTORS = (FLASH_KB <= SECTOR_KB) ? 1 :
                                 (FLASH_KB <= 2 * SECTOR_KB) ? 2 : 3;
    localparam logic [16:0] ARRAY_BASE = 17'h10000 - 17'(FLASH_KB * 1024);
    localparam logic [1:0]  STRAP_WAIT = 2'h2;

    if (FLASH_KB < SECTOR_KB || FLASH_KB > 60 || FLASH_KB % SECTOR_KB != 0)
    begin : g_bad_size
        $error("FLASH_KB must be a multiple of 4 between 4 and 60");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_UNPROT} state_t;

    // Link domain: byte receiver with one-slot acknowledge
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] byte_hold_reg;
    logic       byte_tog_reg;
    logic       ack_pending_reg;
    wire  [7:0] shift_next = {shift_reg[6:0], icc_serial_data_in};

    always_ff @(posedge icc_serial_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg            <= 8'h00;
            bit_cnt_reg          <= 3'h0;
            byte_hold_reg        <= 8'h00;
            byte_tog_reg         <= 1'b0;
            ack_pending_reg      <= 1'b0;
            icc_serial_data_out  <= 1'b1;
            icc_serial_data_oe_n <= 1'b1;
        end
        else
        begin
            icc_serial_data_out  <= 1'b0;
            icc_serial_data_oe_n <= 1'b1;
            ack_pending_reg      <= 1'b0;
            if (!ack_pending_reg)
            begin
                shift_reg   <= shift_next;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7)
                begin
                    byte_hold_reg   <= shift_next;
                    byte_tog_reg    <= !byte_tog_reg;
                    ack_pending_reg <= 1'b1;
                    // Drive ack low through the slot, release at its edge
                    icc_serial_data_oe_n <= 1'b0;
                end
            end
        end
    end

    // Crossings into the core domain
    logic [2:0] pins_sync;
    logic       tog_seen_reg;
    logic       opt_sync;
    sync2 #(.WIDTH(3)) u_sync (
        .clk    (core_clk),
        .resetn (resetn),
        .d      ({tool_attached, socket_mode, byte_tog_reg}),
        .q      (pins_sync)
    );
    sync2 #(.WIDTH(1)) u_opt_sync (
        .clk    (core_clk),
        .resetn (resetn),
        .d      (protect_option_pin),
        .q      (opt_sync)
    );
    wire tool_sync   = pins_sync[2];
    wire socket_sync = pins_sync[1];
    wire byte_event  = pins_sync[0] ^ tog_seen_reg;
    wire entry_byte  = byte_event && byte_hold_reg == ICC_ENTRY_KEY;

    // Core control state
    state_t     state_reg;
    logic [7:0] ctrl_reg;
    logic [1:0] key_reg;
    logic       protect_reg;
    logic       strap_done_reg;
    logic [1:0] strap_wait_reg;
    logic       refused_reg;

    wire tool_mode  = socket_sync || icc_session;
    wire iap_mode   = !tool_mode;
    wire unlocked   = key_reg == 2'h2;
    wire ctrl_wr    = cpu.wr && cpu.addr == CTRL_STATUS_ADDR;
    wire cmd_wr     = ctrl_wr && unlocked && state_reg == ST_IDLE;
    wire key_wr     = ctrl_wr && !unlocked;
    wire in_array   = {1'b0, cpu.addr} >= ARRAY_BASE;
    wire [1:0] hit_sector = (cpu.addr[15:12] == SECTOR0_PAGE) ? 2'd0 :
                            (cpu.addr[15:12] == SECTOR1_PAGE) ? 2'd1 : 2'd2;
    wire sector_ok  = hit_sector < 2'(NUM_SECTORS) && in_array;
    wire mode_ok    = !(iap_mode && hit_sector == 2'd0);
    wire armed_prog = ctrl_reg[CMD_PROG_BIT];
    wire armed_sect = ctrl_reg[CMD_SECT_BIT];
    wire arr_wr     = cpu.wr && in_array && (armed_prog || armed_sect) && state_reg == ST_IDLE;
    wire arr_ok     = arr_wr && sector_ok && mode_ok && !protect_reg;
    wire mass_cmd   = cmd_wr && cpu.wdata[CMD_MASS_BIT];
    wire mass_ok    = mass_cmd && tool_mode && !protect_reg;
    wire opt_cmd    = cmd_wr && cpu.wdata[CMD_OPT_BIT] && tool_mode && IS_FLASH;
    wire unprot_cmd = opt_cmd && !cpu.wdata[CMD_OPT_VAL_BIT] && protect_reg;
    wire refuse_now = (arr_wr && !arr_ok) || (mass_cmd && !mass_ok)
                      || (cmd_wr && cpu.wdata[CMD_OPT_BIT] && !opt_cmd);
    wire [1:0] key_next = (key_wr && key_reg == 2'h0 && cpu.wdata == UNLOCK_KEY1) ? 2'h1 :
                          (key_wr && key_reg == 2'h1 && cpu.wdata == UNLOCK_KEY2) ? 2'h2 :
                          (ctrl_wr) ? 2'h0 : key_reg;

    flash_req_t req_next;
    always_comb
    begin
        req_next        = '0;
        req_next.addr   = cpu.addr;
        req_next.data   = cpu.wdata;
        req_next.sector = hit_sector;
        if (arr_ok)
            req_next.op = armed_prog ? OP_PROG : OP_SECT_ERASE;
        else if (mass_ok || unprot_cmd)
            req_next.op = OP_MASS_ERASE;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg       <= ST_IDLE;
            ctrl_reg        <= CTRL_STATUS_RESET;
            key_reg         <= 2'h0;
            protect_reg     <= 1'b1;
            strap_done_reg  <= 1'b0;
            strap_wait_reg  <= 2'h0;
            refused_reg     <= 1'b0;
            tog_seen_reg    <= 1'b0;
            icc_session     <= 1'b0;
            flash_req       <= '0;
            flash_req_valid <= 1'b0;
        end
        else
        begin
            tog_seen_reg    <= pins_sync[0];
            key_reg         <= key_next;
            flash_req       <= req_next;
            flash_req_valid <= req_next.op != OP_NONE;
            refused_reg     <= refuse_now || (refused_reg && !cmd_wr);
            if (entry_byte && tool_sync)
                icc_session <= 1'b1;
            // Catch strap only once the synchroniser holds the pin
            if (!strap_done_reg)
            begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
                if (strap_wait_reg == STRAP_WAIT)
                begin
                    strap_done_reg <= 1'b1;
                    protect_reg    <= IS_FLASH ? opt_sync : ROM_PROTECT;
                end
            end
            if (cmd_wr)
                ctrl_reg <= cpu.wdata;
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (unprot_cmd)
                        state_reg <= ST_UNPROT;
                    else if (req_next.op != OP_NONE)
                        state_reg <= ST_BUSY;
                    if (opt_cmd && cpu.wdata[CMD_OPT_VAL_BIT])
                        protect_reg <= 1'b1;
                end
                ST_BUSY:
                begin
                    if (flash_done)
                        state_reg <= ST_IDLE;
                end
                ST_UNPROT:
                begin
                    if (flash_done)
                    begin
                        state_reg   <= ST_IDLE;
                        protect_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flash_ctrl_status_rdata <= CTRL_STATUS_RESET;
            read_block              <= 1'b1;
            icc_pins_owned          <= 1'b0;
            readout_protected       <= 1'b1;
        end
        else
        begin
            flash_ctrl_status_rdata <= {state_reg != ST_IDLE, refused_reg, unlocked,
                                        protect_reg, ctrl_reg[3:0]};
            read_block              <= protect_reg && tool_mode;
            icc_pins_owned          <= tool_sync;
            readout_protected       <= protect_reg;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_unprot_start;
        unprot_cmd ##1 (flash_req_valid && flash_req.op == OP_MASS_ERASE);
    endsequence
    sequence s_unprot_hold;
        readout_protected throughout (state_reg == ST_UNPROT)[*1];
    endsequence

    a_iap_sector0_refused: assert property (
        (arr_wr && iap_mode && hit_sector == 2'd0) |=> !flash_req_valid)
        else $error("sector 0 write in application mode not refused");
    a_protect_blocks_write: assert property (
        (arr_wr && protect_reg) |=> !flash_req_valid)
        else $error("array write under protection not refused");
    a_protect_read_block: assert property (
        (protect_reg && tool_mode) |=> read_block)
        else $error("read-out not blocked under protection");
    a_locked_cmd_ignored: assert property (
        (ctrl_wr && !unlocked) |=> $stable(ctrl_reg))
        else $error("command taken while locked");
    a_unprot_erase_first: assert property (
        s_unprot_start |-> s_unprot_hold)
        else $error("protection lifted before mass erase");
    a_unprot_fall_cause: assert property (
        $fell(protect_reg) && $past(strap_done_reg)
        |-> $past(state_reg) == ST_UNPROT && $past(flash_done))
        else $error("protection cleared without erase done");
    a_sector_count: assert property (
        flash_req_valid && flash_req.op != OP_MASS_ERASE |-> flash_req.sector < 2'(NUM_SECTORS))
        else $error("request for missing sector");
    a_sector0_map: assert property (
        (flash_req_valid && flash_req.op == OP_PROG && flash_req.sector == 2'd0)
        |-> flash_req.addr[15:12] == SECTOR0_PAGE)
        else $error("sector 0 outside top page");
    a_tool_full_access: assert property (
        (arr_wr && tool_mode && sector_ok && !protect_reg) |=> flash_req_valid)
        else $error("tool mode write refused");
    a_pins_owned: assert property (
        tool_sync |=> icc_pins_owned)
        else $error("link pins not taken on attach");
    a_rom_fixed: assert property (
        (!IS_FLASH && strap_done_reg) |=> $stable(protect_reg))
        else $error("ROM protection changed");
endmodule

/* rtl/flash_guard_pkg.sv */
package flash_guard_pkg;
    localparam logic [15:0] CTRL_STATUS_ADDR  = 16'h0029;
    localparam logic [7:0]  CTRL_STATUS_RESET = 8'h00;
    localparam logic [3:0]  SECTOR0_PAGE      = 4'hf;
    localparam logic [3:0]  SECTOR1_PAGE      = 4'he;
    localparam int          SECTOR_KB         = 4;
    localparam logic [7:0]  UNLOCK_KEY1       = 8'h56;
    localparam logic [7:0]  UNLOCK_KEY2       = 8'hae;
    localparam logic [7:0]  ICC_ENTRY_KEY     = 8'h35;
    localparam int          CMD_PROG_BIT      = 0;
    localparam int          CMD_SECT_BIT      = 1;
    localparam int          CMD_MASS_BIT      = 2;
    localparam int          CMD_OPT_BIT       = 3;
    localparam int          CMD_OPT_VAL_BIT   = 4;
    localparam int          STAT_BUSY_BIT     = 7;
    localparam int          STAT_REFUSED_BIT  = 6;
    localparam int          STAT_UNLOCK_BIT   = 5;
    localparam int          STAT_PROTECT_BIT  = 4;

    typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_SECT_ERASE, OP_MASS_ERASE} flash_op_t;

    typedef struct packed {
        flash_op_t   op;
        logic [1:0]  sector;
        logic [15:0] addr;
        logic [7:0]  data;
    } flash_req_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpu_bus_t;
endpackage

/* rtl/sync2.sv */
`timescale 1ns/1ps
module sync2
    import flash_guard_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* sim/icc_tool_model.sv */
`timescale 1ns/1ps
module icc_tool_model (
    output logic      icc_serial_clock,
    output logic      tool_data,
    output logic      tool_attached,
    input  wire logic line,
    input  wire logic dev_oe_n
);
    initial
    begin
        icc_serial_clock = 1'b0;
        tool_data        = 1'b1;
        tool_attached    = 1'b0;
    end
    // Plugging the tool
    task automatic attach(input logic on);
        tool_attached <= on;
    endtask
    // Byte MSB first, clock still outside the frame, tool drives the inverted last bit in ack slot
    task automatic send_byte(input logic [7:0] b, output logic [1:0] ack);
        #5;
        for (int i = 7; i >= 0; i--)
        begin
            tool_data = b[i];
            #16 icc_serial_clock = 1'b1;
            #16 icc_serial_clock = 1'b0;
        end
        tool_data = ~b[0];
        #8 ack = {dev_oe_n, line};
        #8 icc_serial_clock = 1'b1;
        #16 icc_serial_clock = 1'b0;
        tool_data = 1'b1;
    endtask
endmodule

/* sim/flash_sector_program_guard_tb.sv */
`timescale 1ns/1ps
module flash_sector_program_guard_tb
    import flash_guard_pkg::*;
;
    logic       core_clk;
    logic       resetn;
    logic       icc_serial_clock;
    logic       tool_data;
    logic       icc_line;
    logic       data_out;
    logic       oe_n;
    logic       tool_attached;
    logic       socket_mode;
    logic       protect_option_pin;
    cpu_bus_t   cpu;
    logic       flash_done;
    flash_req_t flash_req;
    flash_req_t last_req;
    logic       flash_req_valid;
    logic [7:0] rdata;
    logic       read_block;
    logic       pins_owned;
    logic       session;
    logic       prot;
    logic       prot_at_req;
    logic [3:0] done_sr;
    logic [1:0] ack;
    int         req_count;
    int         cycles;
    int         err_count;
    int         checks;

    flash_sector_program_guard u_flash_sector_program_guard (
        .core_clk                (core_clk),
        .resetn                  (resetn),
        .icc_serial_clock        (icc_serial_clock),
        .icc_serial_data_in      (icc_line),
        .icc_serial_data_out     (data_out),
        .icc_serial_data_oe_n    (oe_n),
        .tool_attached           (tool_attached),
        .socket_mode             (socket_mode),
        .protect_option_pin      (protect_option_pin),
        .cpu                     (cpu),
        .flash_done              (flash_done),
        .flash_req               (flash_req),
        .flash_req_valid         (flash_req_valid),
        .flash_ctrl_status_rdata (rdata),
        .read_block              (read_block),
        .icc_pins_owned          (pins_owned),
        .icc_session             (session),
        .readout_protected       (prot)
    );
    icc_tool_model u_icc_tool_model (
        .icc_serial_clock (icc_serial_clock),
        .tool_data        (tool_data),
        .tool_attached    (tool_attached),
        .line             (icc_line),
        .dev_oe_n         (oe_n)
    );
    assign icc_line = oe_n ? tool_data : data_out;

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Array answers, request log, hang limit
    always @(posedge core_clk)
    begin
        done_sr    <= {done_sr[2:0], flash_req_valid === 1'b1};
        flash_done <= done_sr[3];
        cycles     <= cycles + 1;
        if (flash_req_valid === 1'b1)
        begin
            req_count   <= req_count + 1;
            last_req    <= flash_req;
            prot_at_req <= prot;
        end
        if (cycles == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic do_reset;
        @(posedge core_clk) resetn <= 1'b0;
        repeat (6) @(posedge core_clk);
        check(rdata, CTRL_STATUS_RESET);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk) cpu <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk) cpu.wr <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(CTRL_STATUS_ADDR, UNLOCK_KEY1);
        wr(CTRL_STATUS_ADDR, UNLOCK_KEY2);
        wr(CTRL_STATUS_ADDR, c);
    endtask
    // Request count since n0 and the kind of the last one
    task automatic expect_req(input int n0, input logic ok, input flash_op_t op);
        repeat (12) @(posedge core_clk);
        check(req_count - n0, {31'h0, ok});
        if (ok)
            check(last_req.op, op);
    endtask
    task automatic prog(input flash_op_t op, input logic [15:0] a, input logic [1:0] s,
                        input logic ok);
        int n0;
        n0 = req_count;
        wr(a, 8'h5a);
        expect_req(n0, ok, op);
        if (ok)
            check(last_req, {op, s, a, 8'h5a});
    endtask

    task automatic scen_locked;
        check({session, pins_owned, prot, read_block}, 4'h0);
        wr(CTRL_STATUS_ADDR, 8'h01);
        repeat (3) @(posedge core_clk);
        check(rdata[3:0], 4'h0);
        prog(OP_PROG, 16'he010, 2'h1, 1'b0);
    endtask
    task automatic scen_app;
        cmd(8'h01);
        repeat (3) @(posedge core_clk);
        check({rdata[STAT_UNLOCK_BIT], rdata[3:0]}, 5'h01);
        prog(OP_PROG, 16'he010, 2'h1, 1'b1);
        prog(OP_PROG, 16'h8010, 2'h2, 1'b1);
        prog(OP_PROG, 16'h4010, 2'h2, 1'b0);
        prog(OP_PROG, 16'hf010, 2'h0, 1'b0);
        check(rdata[STAT_REFUSED_BIT], 1'b1);
        cmd(8'h02);
        prog(OP_SECT_ERASE, 16'he000, 2'h1, 1'b1);
        cmd(8'h04);
        expect_req(req_count, 1'b0, OP_MASS_ERASE);
    endtask
    task automatic scen_socket;
        socket_mode <= 1'b1;
        cmd(8'h01);
        prog(OP_PROG, 16'hf010, 2'h0, 1'b1);
        cmd(8'h04);
        expect_req(req_count, 1'b1, OP_MASS_ERASE);
        socket_mode <= 1'b0;
    endtask
    task automatic scen_icc;
        u_icc_tool_model.attach(1'b1);
        repeat (6) @(posedge core_clk);
        check({pins_owned, session}, 2'h2);
        u_icc_tool_model.send_byte(ICC_ENTRY_KEY, ack);
        check(ack, 2'h0);
        repeat (10) @(posedge core_clk);
        check(session, 1'b1);
        cmd(8'h01);
        prog(OP_PROG, 16'hf020, 2'h0, 1'b1);
    endtask
    task automatic scen_protect;
        protect_option_pin <= 1'b1;
        socket_mode        <= 1'b1;
        do_reset();
        check({prot, read_block}, 2'h3);
        cmd(8'h01);
        prog(OP_PROG, 16'he010, 2'h1, 1'b0);
        cmd(8'h08);
        expect_req(req_count, 1'b1, OP_MASS_ERASE);
        check(prot_at_req, 1'b1);
        check({prot, read_block}, 2'h0);
    endtask

    initial
    begin
        resetn             = 1'b0;
        socket_mode        = 1'b0;
        protect_option_pin = 1'b0;
        cpu                = '0;
        flash_done         = 1'b0;
        done_sr            = 4'h0;
        last_req           = '0;
        prot_at_req        = 1'b0;
        req_count          = 0;
        cycles             = 0;
        err_count          = 0;
        checks             = 0;
        do_reset();
        scen_locked();
        scen_app();
        scen_socket();
        scen_icc();
        scen_protect();
        give_verdict();
    end
endmodule
